// ===== inc/jog_pkg.sv
package jog_pkg;
  localparam int POS_WIDTH = 32;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  // Pulse rate and direction setup time
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int PULSE_FREQ_HZ = 30_000;
  localparam int HALF_PERIOD_CYCLES = CLK_FREQ_HZ / (2 * PULSE_FREQ_HZ);
  localparam int DIR_SETUP_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DIR_SETUP_CYCLES = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_POS_LOW = 4'h3;
  localparam logic [3:0] ADDR_POS_HIGH = 4'h4;
  // Status and control bit positions
  localparam int ST_ABNORMAL = 0;
  localparam int ST_STOPPED = 1;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_ACTIVE = 1;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  typedef enum logic {MODE_PULSE_DIR, MODE_FWD_REV} pulse_mode_t;
endpackage

// ===== rtl/input_sync.sv
`timescale 1ns/10ps
module input_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, out_reg;
  logic [WIDTH-1:0] out_next;

  // Change accepted once stages two and three agree
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        out_next[i] = stage3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      out_reg <= '0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      out_reg <= out_next;
    end
  end

  assign syncOut = out_reg;
endmodule // input_sync

// ===== rtl/pulse_gen.sv
`timescale 1ns/10ps
module pulse_gen #(
  parameter int HALF_PERIOD = 1667
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  output logic pulseLevel,
  output logic pulseRise
);
  logic [31:0] count_reg, count_next;
  logic level_reg, level_next;
  logic rise_reg, rise_next;

  always_comb begin
    count_next = count_reg;
    level_next = level_reg;
    rise_next = 1'b0;
    if (!run) begin
      count_next = '0;
      level_next = 1'b0;
    end else if (count_reg == 32'(HALF_PERIOD - 1)) begin
      count_next = '0;
      level_next = !level_reg;
      rise_next = !level_reg;
    end else begin
      count_next = count_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= '0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign pulseLevel = level_reg;
  assign pulseRise = rise_reg;
endmodule // pulse_gen

// ===== rtl/jog_pulse_output_reverse.sv
`timescale 1ns/10ps
module jog_pulse_output_reverse #(
  parameter int HALF_PERIOD = jog_pkg::HALF_PERIOD_CYCLES,
  parameter int DIR_SETUP = jog_pkg::DIR_SETUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fwdLimitIn,
  input wire logic revLimitIn,
  input wire logic fwdJogIn,
  input wire logic revJogIn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regReadData,
  output logic pulseOut,
  output logic dirOut,
  output logic irq
);
  typedef enum logic [1:0] {IDLE, SETUP, RUN, HALT} state_t;

  logic [3:0] syncIn;
  logic fwdLimitOk, revLimitOk, fwdJog, revJog;
  logic pulseLevel, pulseRise;
  state_t state_reg, state_next;
  logic [31:0] setup_reg, setup_next;
  logic [31:0] position_reg, position_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [1:0] status_reg, status_next;
  logic [1:0] mask_reg, mask_next;
  logic pulse_reg, pulse_next;
  logic dir_reg, dir_next;
  logic irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic running, limitStop, normalStop;
  jog_pkg::pulse_mode_t mode;

  // Write strobe aimed at one register index
  function automatic logic wrHit(input logic we, input logic [3:0] a, input logic [3:0] idx);
    return we && (a == idx);
  endfunction

  input_sync #(.WIDTH(4)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn({revJogIn, fwdJogIn, revLimitIn, fwdLimitIn}),
    .syncOut(syncIn)
  );

  assign fwdLimitOk = syncIn[0];
  assign revLimitOk = syncIn[1];
  assign fwdJog = syncIn[2];
  assign revJog = syncIn[3];
  assign mode = jog_pkg::pulse_mode_t'(ctrl_reg[jog_pkg::CTRL_MODE]);
  assign running = (state_reg == RUN);

  pulse_gen #(.HALF_PERIOD(HALF_PERIOD)) u_pulse (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(running),
    .pulseLevel(pulseLevel),
    .pulseRise(pulseRise)
  );

  // Motion sequencer
  always_comb begin
    state_next = state_reg;
    setup_next = setup_reg;
    limitStop = 1'b0;
    normalStop = 1'b0;
    case (state_reg)
      IDLE: begin
        if (revJog && !fwdJog && fwdLimitOk && revLimitOk) begin
          state_next = SETUP;
          setup_next = '0;
        end
      end
      SETUP: begin
        if (!revLimitOk) begin
          limitStop = 1'b1;
          state_next = HALT;
        end else if (!revJog || fwdJog) begin
          normalStop = 1'b1;
          state_next = IDLE;
        end else if (setup_reg == 32'(DIR_SETUP - 1)) begin
          state_next = RUN;
        end else begin
          setup_next = setup_reg + 32'h1;
        end
      end
      RUN: begin
        if (!revLimitOk) begin
          limitStop = 1'b1;
          state_next = HALT;
        end else if (!revJog) begin
          normalStop = 1'b1;
          state_next = IDLE;
        end
      end
      HALT: begin
        // Wait for jog release before a new move
        if (!revJog) begin
          state_next = IDLE;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  // Outputs and position
  always_comb begin
    position_next = position_reg;
    pulse_next = 1'b0;
    dir_next = dir_reg;
    if (state_reg == SETUP || running) begin
      if (mode == jog_pkg::MODE_PULSE_DIR) begin
        dir_next = 1'b0;
      end else begin
        dir_next = pulseLevel;
      end
    end
    if (running && state_next == RUN) begin
      if (mode == jog_pkg::MODE_PULSE_DIR) begin
        pulse_next = pulseLevel;
      end else begin
        pulse_next = 1'b0;
      end
      if (pulseRise) begin
        position_next = position_reg - 32'h1;
      end
    end
    if (mode == jog_pkg::MODE_FWD_REV && state_next != RUN) begin
      dir_next = 1'b0;
    end
    if (wrHit(regWrite, regAddr, jog_pkg::ADDR_POS_LOW)) begin
      position_next[15:0] = regWriteData[15:0];
    end
    if (wrHit(regWrite, regAddr, jog_pkg::ADDR_POS_HIGH)) begin
      position_next[31:16] = regWriteData[15:0];
    end
  end

  // Register file and interrupt
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    rdata_next = '0;
    if (wrHit(regWrite, regAddr, jog_pkg::ADDR_CTRL)) begin
      ctrl_next[jog_pkg::CTRL_MODE] = regWriteData[jog_pkg::CTRL_MODE];
    end
    if (wrHit(regWrite, regAddr, jog_pkg::ADDR_MASK)) begin
      mask_next = regWriteData[1:0];
    end
    if (wrHit(regWrite, regAddr, jog_pkg::ADDR_STATUS)) begin
      status_next = status_reg & ~regWriteData[1:0];
    end
    // Set wins over clear
    if (limitStop) begin
      status_next[jog_pkg::ST_ABNORMAL] = 1'b1;
    end
    if (normalStop) begin
      status_next[jog_pkg::ST_STOPPED] = 1'b1;
    end
    ctrl_next[jog_pkg::CTRL_ACTIVE] = (state_next == SETUP || state_next == RUN);
    irq_next = |(status_next & mask_next);
    if (regRead) begin
      case (regAddr)
        jog_pkg::ADDR_CTRL: rdata_next = {30'h0, ctrl_reg};
        jog_pkg::ADDR_STATUS: rdata_next = {30'h0, status_reg};
        jog_pkg::ADDR_MASK: rdata_next = {30'h0, mask_reg};
        jog_pkg::ADDR_POS_LOW: rdata_next = {16'h0, position_reg[15:0]};
        jog_pkg::ADDR_POS_HIGH: rdata_next = {16'h0, position_reg[31:16]};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= IDLE;
      setup_reg <= '0;
      position_reg <= jog_pkg::POS_RESET;
      ctrl_reg <= jog_pkg::CTRL_RESET;
      status_reg <= jog_pkg::STATUS_RESET;
      mask_reg <= jog_pkg::MASK_RESET;
      pulse_reg <= 1'b0;
      dir_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      setup_reg <= setup_next;
      position_reg <= position_next;
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      pulse_reg <= pulse_next;
      dir_reg <= dir_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pulseOut = pulse_reg;
  assign dirOut = dir_reg;
  assign irq = irq_reg;
  assign regReadData = rdata_reg;
endmodule // jog_pulse_output_reverse

// ===== bench/jog_pulse_output_reverse_chk.sv
`timescale 1ns/10ps
module jog_pulse_output_reverse_chk #(
  parameter int HALF_PERIOD = 4,
  parameter int DIR_SETUP = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fwdLimitIn,
  input wire logic revLimitIn,
  input wire logic fwdJogIn,
  input wire logic revJogIn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regReadData,
  input wire logic pulseOut,
  input wire logic dirOut,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence limitOpen;
    (!revLimitIn)[*8];
  endsequence
  sequence jogOff;
    (!revJogIn)[*8];
  endsequence
  a_limit_stop: assert property (limitOpen |=> ##1 !pulseOut) else $error("pulse with limit open");
  a_release_stop: assert property (jogOff |=> ##1 !pulseOut) else $error("pulse after release");
  a_dir_on_pulse: assert property ($rose(pulseOut) |-> !dirOut) else $error("pulse with dir high");
  a_pulse_gap: assert property ($fell(pulseOut) |=> !pulseOut[*3]) else $error("low half too short");
  a_fwd_blocks: assert property ((fwdJogIn && !pulseOut)[*8] |=> !pulseOut) else $error("start with fwd jog");
  a_read_idle: assert property (!$past(regRead) |-> regReadData == 32'h0) else $error("stray read data");
  a_unmapped_read: assert property (regRead && regAddr > 4'h4 |=> regReadData == 32'h0) else $error("unmapped data");
  a_irq_masked: assert property (regWrite && regAddr == 4'h2 && regWriteData[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq while masked");
endmodule // jog_pulse_output_reverse_chk
bind jog_pulse_output_reverse jog_pulse_output_reverse_chk #(.HALF_PERIOD(HALF_PERIOD), .DIR_SETUP(DIR_SETUP)) u_chk (
  .sys_clk, .reset, .fwdLimitIn, .revLimitIn, .fwdJogIn, .revJogIn, .regAddr, .regWriteData,
  .regWrite, .regRead, .regReadData, .pulseOut, .dirOut, .irq);

// ===== bench/jog_drive_model.sv
`timescale 1ns/10ps
module jog_drive_model (
  input wire logic sys_clk,
  input wire logic stepIn,
  output int stepCount
);
  logic lastStep = 1'b0;
  int steps = 0;
  // Drive steps once per rising edge of its step input
  always @(posedge sys_clk) begin
    if (stepIn && !lastStep) steps <= steps + 1;
    lastStep <= stepIn;
  end
  assign stepCount = steps;
endmodule // jog_drive_model

// ===== bench/jog_pulse_output_reverse_tb_top.sv
`timescale 1ns/10ps
module jog_pulse_output_reverse_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic fwdLimitIn = 1'b1;
  logic revLimitIn = 1'b1;
  logic fwdJogIn = 1'b0;
  logic revJogIn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regReadData;
  logic pulseOut;
  logic dirOut;
  logic irq;
  logic modeSel = 1'b0;
  logic [31:0] rdVal;
  int fails = 0;
  int check_count = 0;
  int fwdStray = 0;
  int stepCount;
  int base;
  logic [35:0] rows [6] = '{{4'h0, 32'h0}, {4'h1, 32'h0}, {4'h2, 32'h0}, {4'h3, 32'h0}, {4'h4, 32'h0}, {4'hf, 32'h0}};

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  jog_pulse_output_reverse #(.HALF_PERIOD(4), .DIR_SETUP(2)) u_jog_pulse_output_reverse (
    .sys_clk, .reset, .fwdLimitIn, .revLimitIn, .fwdJogIn, .revJogIn, .regAddr, .regWriteData,
    .regWrite, .regRead, .regReadData, .pulseOut, .dirOut, .irq);
  jog_drive_model u_jog_drive_model (.sys_clk, .stepIn(modeSel ? dirOut : pulseOut), .stepCount);

  // Forward train must stay quiet in two-train mode
  always @(posedge sys_clk) begin
    if (modeSel && pulseOut !== 1'b0) fwdStray++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rdVal = regReadData;
  endtask

  task automatic run(input logic mode, input logic byLimit);
    modeSel <= mode;
    wr(4'h0, {31'h0, mode});
    wr(4'h3, 32'h40);
    wr(4'h4, 32'h0);
    base = stepCount;
    revJogIn <= 1'b1;
    repeat (80) @(posedge sys_clk);
    if (byLimit) revLimitIn <= 1'b0;
    else revJogIn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    base = stepCount - base;
    chk("moved", 32'(base > 2), 32'h1);
    chk("pulse", {31'h0, pulseOut}, 32'h0);
    chk("dir", {31'h0, dirOut}, 32'h0);
    chk("fwd", 32'(fwdStray), 32'h0);
    rd(4'h3);
    chk("pos", rdVal, 32'h40 - 32'(base));
    repeat (20) @(posedge sys_clk);
    rd(4'h3);
    chk("hold", rdVal, 32'h40 - 32'(base));
    rd(4'h1);
    chk("status", rdVal, byLimit ? 32'h1 : 32'h2);
    chk("irq", {31'h0, irq}, {31'h0, byLimit});
    revJogIn <= 1'b0;
    revLimitIn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    wr(4'h1, 32'h3);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    wr(4'hf, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      rd(rows[i][35:32]);
      chk("reg", rdVal, rows[i][31:0]);
    end
    wr(4'h2, 32'h1);
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    run(1'b0, 1'b1);
    run(1'b1, 1'b1);
    // Start refused with limit open, then with forward jog held
    base = stepCount;
    revLimitIn <= 1'b0;
    revJogIn <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("lim_start", 32'(stepCount - base), 32'h0);
    revLimitIn <= 1'b1;
    fwdJogIn <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("fwd_start", 32'(stepCount - base), 32'h0);
    fwdJogIn <= 1'b0;
    revJogIn <= 1'b0;
    wr(4'h2, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule // jog_pulse_output_reverse_tb_top
